//--- src/uce_pkg.sv
package uce_pkg;
    // Register offsets on the three address lines.
    localparam logic [2:0] A_DATA = 3'h0;
    localparam logic [2:0] A_IER = 3'h1;
    localparam logic [2:0] A_ISR = 3'h2;
    localparam logic [2:0] A_LCR = 3'h3;
    localparam logic [2:0] A_MCR = 3'h4;
    localparam logic [2:0] A_LSR = 3'h5;
    localparam logic [2:0] A_MSR = 3'h6;
    localparam logic [2:0] A_SPR = 3'h7;
    // Enhanced set, visible when line control holds the access key.
    localparam logic [2:0] A_TRG = 3'h0;
    localparam logic [2:0] A_FEATURE_CONTROL_REG = 3'h1;
    localparam logic [2:0] A_EFR = 3'h2;
    localparam logic [2:0] A_XON1 = 3'h4;
    localparam logic [2:0] A_XON2 = 3'h5;
    localparam logic [2:0] A_XOFF1 = 3'h6;
    localparam logic [2:0] A_XOFF2 = 3'h7;
    localparam logic [7:0] LCR_KEY = 8'hBF;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] DIV_ZERO = 8'h00;
    // Field positions.
    localparam int LCR_DIV = 7;
    localparam int EFR_SPEC = 5;
    localparam int EFR_ENH = 4;
    localparam int EFR_ARTS = 6;
    localparam int EFR_ACTS = 7;
    localparam int IER_SLEEP = 4;
    localparam int FEATURE_CONTROL_REG_HD = 3;
    localparam int FEATURE_CONTROL_REG_IRINV = 2;
    localparam int FEATURE_CONTROL_REG_FIFO_FILL_LEVEL = 6;
    localparam int MODE_SELECT_EXTRA_HDINV = 3;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OP1 = 2;
    localparam int MCR_OP2 = 3;
    localparam int MCR_LOOP = 4;
    localparam int MCR_IR = 6;
    // Infrared timing in ticks of the sixteen-times baud clock.
    localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
    localparam logic [3:0] IR_BIT_TICKS = 4'hF;
endpackage

//--- src/uce_channel.sv
`timescale 1ns/1ps
module uce_channel #(
    parameter logic [7:0] REV_CODE = 8'h01,  // Arbitrary value.
    parameter logic [7:0] DEV_ID = 8'h5A     // Arbitrary value.
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic channel_select_n,
    input wire logic host_write_strobe_n,
    input wire logic host_read_strobe_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic thr_wr,
    output logic fcr_wr,
    output logic trg_wr,
    output logic rhr_rd,
    output logic [7:0] wr_byte,
    input wire logic [7:0] rhr_in,
    input wire logic [7:0] lsr_in,
    input wire logic [7:0] fc_in,
    input wire logic [7:0] fifo_fill_level_in,
    input wire logic [3:0] isr_src_in,
    input wire logic fifo_en,
    input wire logic int_other,
    input wire logic baud16,
    input wire logic tx_shift_bit,
    input wire logic tx_bit_start,
    input wire logic tx_busy,
    output logic tx_go,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    output logic rx_fifo_wr,
    output logic rx_shift_in,
    input wire logic rx_pin,
    output logic tx_pin,
    output logic rts_n,
    output logic dtr_n,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic cd_n,
    input wire logic ri_n,
    output logic auto_rts_en,
    output logic auto_cts_en,
    output logic sleep_ok,
    input wire logic peer_sleep_ok,
    output logic osc_run
);
    logic [7:0] lcr_r, ier_r, mcr_r, efr_r, feature_control_reg_r, mode_select_extra_r, spr_r, dll_r, dlm_r;
    logic [7:0] xon1_r, xon2_r, xoff1_r, xoff2_r;
    logic wr_prev_r, rd_prev_r, wr_acc, rd_acc;
    logic spec_flag_r, spec_match, pending;
    logic [3:0] mdm_raw, mdm_prev_r, delta_r, mdm_chg;
    logic rts_act_r, ir_pulse_r, ir_bit_r, sleep_r, rx_prev_r, entry_ok, wake;
    logic [3:0] ir_cnt_r, dec_cnt_r;
    logic loop, ir_mode, rx_line, rx_ir_in, key;

    // Word-length mask: LINE_CONTROL_REG bits 1:0 pick 5 to 8 data bits.
    function automatic logic [7:0] len_mask(input logic [1:0] wl);
        len_mask = 8'hFF >> (2'h3 - wl);
    endfunction

    // Address compare shared by the write, pulse and flag decodes.
    function automatic logic hit(input logic [2:0] a, input logic [2:0] want);
        hit = (a == want);
    endfunction

    assign loop = mcr_r[uce_pkg::MCR_LOOP];
    assign ir_mode = mcr_r[uce_pkg::MCR_IR];
    assign key = (lcr_r == uce_pkg::LCR_KEY);

    // Strobes are level inputs; an access is taken once, on the first low cycle.
    assign wr_acc = !channel_select_n && !host_write_strobe_n && wr_prev_r;
    assign rd_acc = !channel_select_n && !host_read_strobe_n && rd_prev_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_prev_r <= 1'b1;
            rd_prev_r <= 1'b1;
        end else if (clk_en) begin
            wr_prev_r <= channel_select_n || host_write_strobe_n;
            rd_prev_r <= channel_select_n || host_read_strobe_n;
        end
    end

    // Register writes.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lcr_r <= uce_pkg::REG_RST;
            ier_r <= uce_pkg::REG_RST;
            mcr_r <= uce_pkg::REG_RST;
            efr_r <= uce_pkg::REG_RST;
            feature_control_reg_r <= uce_pkg::REG_RST;
            mode_select_extra_r <= uce_pkg::REG_RST;
            spr_r <= uce_pkg::REG_RST;
            dll_r <= uce_pkg::REG_RST;
            dlm_r <= uce_pkg::REG_RST;
            xon1_r <= uce_pkg::REG_RST;
            xon2_r <= uce_pkg::REG_RST;
            xoff1_r <= uce_pkg::REG_RST;
            xoff2_r <= uce_pkg::REG_RST;
        end else if (clk_en && wr_acc) begin
            if (hit(addr, uce_pkg::A_LCR)) begin
                lcr_r <= wdata;
            end else if (key) begin
                case (addr)
                    uce_pkg::A_FEATURE_CONTROL_REG: feature_control_reg_r <= wdata;
                    uce_pkg::A_EFR: efr_r <= wdata;
                    uce_pkg::A_XON1: xon1_r <= wdata;
                    uce_pkg::A_XON2: xon2_r <= wdata;
                    uce_pkg::A_XOFF1: xoff1_r <= wdata;
                    uce_pkg::A_XOFF2: xoff2_r <= wdata;
                    default: ;
                endcase
            end else begin
                case (addr)
                    uce_pkg::A_DATA: if (lcr_r[uce_pkg::LCR_DIV]) dll_r <= wdata;
                    uce_pkg::A_IER: begin
                        if (lcr_r[uce_pkg::LCR_DIV]) begin
                            dlm_r <= wdata;
                        end else if (efr_r[uce_pkg::EFR_ENH]) begin
                            ier_r <= wdata;
                        end else begin
                            // Upper enable bits stay locked until enhanced access is on.
                            ier_r <= {ier_r[7:4], wdata[3:0]};
                        end
                    end
                    uce_pkg::A_MCR: mcr_r <= wdata;
                    uce_pkg::A_SPR: begin
                        if (feature_control_reg_r[uce_pkg::FEATURE_CONTROL_REG_FIFO_FILL_LEVEL]) mode_select_extra_r <= wdata;
                        else spr_r <= wdata;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Write and read pulses and data to the FIFO and baud logic outside this block.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            thr_wr <= 1'b0;
            fcr_wr <= 1'b0;
            trg_wr <= 1'b0;
            rhr_rd <= 1'b0;
            wr_byte <= uce_pkg::REG_RST;
        end else if (clk_en) begin
            thr_wr <= wr_acc && !key && !lcr_r[uce_pkg::LCR_DIV] && hit(addr, uce_pkg::A_DATA);
            fcr_wr <= wr_acc && !key && hit(addr, uce_pkg::A_ISR);
            trg_wr <= wr_acc && key && hit(addr, uce_pkg::A_TRG);
            rhr_rd <= rd_acc && !key && !lcr_r[uce_pkg::LCR_DIV] && hit(addr, uce_pkg::A_DATA);
            if (wr_acc) wr_byte <= wdata;
        end
    end

    // Read data, held in a flip-flop until the next read.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= uce_pkg::REG_RST;
        end else if (clk_en && rd_acc) begin
            if (key) begin
                case (addr)
                    uce_pkg::A_TRG: rdata <= fc_in;
                    uce_pkg::A_FEATURE_CONTROL_REG: rdata <= feature_control_reg_r;
                    uce_pkg::A_EFR: rdata <= efr_r;
                    uce_pkg::A_LCR: rdata <= lcr_r;
                    uce_pkg::A_XON1: rdata <= xon1_r;
                    uce_pkg::A_XON2: rdata <= xon2_r;
                    uce_pkg::A_XOFF1: rdata <= xoff1_r;
                    default: rdata <= xoff2_r;
                endcase
            end else begin
                case (addr)
                    uce_pkg::A_DATA: begin
                        if (!lcr_r[uce_pkg::LCR_DIV]) rdata <= rhr_in;
                        else if (dll_r == uce_pkg::DIV_ZERO && dlm_r == uce_pkg::DIV_ZERO)
                            rdata <= REV_CODE;
                        else rdata <= dll_r;
                    end
                    uce_pkg::A_IER: begin
                        if (!lcr_r[uce_pkg::LCR_DIV]) rdata <= ier_r;
                        else if (dll_r == uce_pkg::DIV_ZERO && dlm_r == uce_pkg::DIV_ZERO)
                            rdata <= DEV_ID;
                        else rdata <= dlm_r;
                    end
                    uce_pkg::A_ISR: rdata <= {fifo_en, fifo_en, 1'b0, spec_flag_r,
                                              isr_src_in[3:1], !pending};
                    uce_pkg::A_LCR: rdata <= lcr_r;
                    uce_pkg::A_MCR: rdata <= mcr_r;
                    uce_pkg::A_LSR: rdata <= lsr_in;
                    uce_pkg::A_MSR: rdata <= {mdm_raw, delta_r};
                    default: rdata <= feature_control_reg_r[uce_pkg::FEATURE_CONTROL_REG_FIFO_FILL_LEVEL] ? fifo_fill_level_in : spr_r;
                endcase
            end
        end
    end

    // Special character detect. The character is never withheld from the FIFO.
    assign rx_fifo_wr = rx_char_valid;
    assign spec_match = rx_char_valid && efr_r[uce_pkg::EFR_SPEC] &&
        ((rx_char & len_mask(lcr_r[1:0])) == (xoff2_r & len_mask(lcr_r[1:0])));

    // Cleared by reading the status register; a match in that cycle wins.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spec_flag_r <= 1'b0;
        end else if (clk_en) begin
            if (spec_match) spec_flag_r <= 1'b1;
            else if (rd_acc && !key && hit(addr, uce_pkg::A_ISR)) spec_flag_r <= 1'b0;
        end
    end

    // Modem inputs, active low on the pins, as active-high bits CD, RI, DSR, CTS.
    always_comb begin
        if (loop) begin
            mdm_raw = {mcr_r[uce_pkg::MCR_OP2], mcr_r[uce_pkg::MCR_OP1],
                       mcr_r[uce_pkg::MCR_DTR], mcr_r[uce_pkg::MCR_RTS]};
        end else begin
            mdm_raw = {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
        end
    end
    assign mdm_chg = mdm_raw ^ mdm_prev_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mdm_prev_r <= 4'h0;
            delta_r <= 4'h0;
        end else if (clk_en) begin
            mdm_prev_r <= mdm_raw;
            if (rd_acc && !key && hit(addr, uce_pkg::A_MSR)) delta_r <= mdm_chg;
            else delta_r <= delta_r | mdm_chg;
        end
    end

    // Half-duplex direction: asserted while data waits or shifts, released after.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rts_act_r <= 1'b0;
        end else if (clk_en) begin
            if (feature_control_reg_r[uce_pkg::FEATURE_CONTROL_REG_HD]) rts_act_r <= tx_busy;
            else rts_act_r <= mcr_r[uce_pkg::MCR_RTS];
        end
    end
    // The shifter waits one cycle, so the pin turns no later than the start bit.
    assign tx_go = !feature_control_reg_r[uce_pkg::FEATURE_CONTROL_REG_HD] || rts_act_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rts_n <= 1'b1;
            dtr_n <= 1'b1;
        end else if (clk_en) begin
            if (loop) begin
                rts_n <= 1'b1;
                dtr_n <= 1'b1;
            end else begin
                rts_n <= !rts_act_r ^ (feature_control_reg_r[uce_pkg::FEATURE_CONTROL_REG_HD] &&
                                       mode_select_extra_r[uce_pkg::MODE_SELECT_EXTRA_HDINV]);
                dtr_n <= !mcr_r[uce_pkg::MCR_DTR];
            end
        end
    end

    assign auto_rts_en = efr_r[uce_pkg::EFR_ARTS] && !loop;
    assign auto_cts_en = efr_r[uce_pkg::EFR_ACTS] && !loop;

    // Infrared encoder: a pulse opens with each zero bit cell.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ir_pulse_r <= 1'b0;
            ir_bit_r <= 1'b1;
            ir_cnt_r <= 4'h0;
        end else if (clk_en) begin
            if (tx_bit_start) begin
                ir_bit_r <= tx_shift_bit;
                ir_pulse_r <= !tx_shift_bit;
                ir_cnt_r <= 4'h0;
            end else if (baud16 && ir_pulse_r) begin
                ir_cnt_r <= ir_cnt_r + 4'h1;
                if (ir_cnt_r + 4'h1 == uce_pkg::IR_PULSE_TICKS) ir_pulse_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_pin <= 1'b1;
        end else if (clk_en) begin
            if (loop) tx_pin <= !ir_mode;
            else if (ir_mode) tx_pin <= ir_pulse_r;
            else tx_pin <= tx_shift_bit;
        end
    end

    // Infrared decoder: a light pulse becomes a zero held for one bit time.
    assign rx_ir_in = rx_pin ^ feature_control_reg_r[uce_pkg::FEATURE_CONTROL_REG_IRINV];
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dec_cnt_r <= 4'h0;
        end else if (clk_en) begin
            if (ir_mode && rx_ir_in) dec_cnt_r <= uce_pkg::IR_BIT_TICKS;
            else if (baud16 && dec_cnt_r != 4'h0) dec_cnt_r <= dec_cnt_r - 4'h1;
        end
    end
    assign rx_line = ir_mode ? (dec_cnt_r == 4'h0) : rx_pin;
    assign rx_shift_in = loop ? (ir_mode ? !ir_pulse_r : tx_shift_bit) : rx_line;

    // Sleep control. Wake is checked in the same cycle so an event is never lost.
    assign pending = spec_flag_r || int_other || (delta_r != 4'h0);
    assign sleep_ok = ier_r[uce_pkg::IER_SLEEP] && !pending && delta_r == 4'h0 &&
                      rx_line && !tx_busy;
    assign entry_ok = sleep_ok && peer_sleep_ok;
    assign wake = (rx_prev_r && !rx_line) || thr_wr || (mdm_chg != 4'h0);
    assign osc_run = !sleep_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sleep_r <= 1'b0;
            rx_prev_r <= 1'b1;
        end else if (clk_en) begin
            rx_prev_r <= rx_line;
            sleep_r <= entry_ok && !wake;
        end
    end

    a_spec_set: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && spec_match |=> spec_flag_r) else $error("special flag not set");
    a_spec_gate: assert property (@(posedge clk) disable iff (sys_rst)
        !spec_flag_r && !(rx_char_valid && efr_r[uce_pkg::EFR_SPEC]) |=> !spec_flag_r)
        else $error("special flag set while detect off");
    a_spec_len: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && rx_char_valid && efr_r[uce_pkg::EFR_SPEC] && lcr_r[1:0] == 2'h0 &&
        rx_char[4:0] == xoff2_r[4:0] |=> spec_flag_r) else $error("5-bit match missed");
    a_hd_release: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && feature_control_reg_r[uce_pkg::FEATURE_CONTROL_REG_HD] && !tx_busy ##1 clk_en && feature_control_reg_r[uce_pkg::FEATURE_CONTROL_REG_HD] &&
        !loop |=> rts_n == !$past(mode_select_extra_r[uce_pkg::MODE_SELECT_EXTRA_HDINV]))
        else $error("direction not released");
    a_hd_before: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && feature_control_reg_r[uce_pkg::FEATURE_CONTROL_REG_HD] && !loop && tx_go
        |=> rts_n == $past(mode_select_extra_r[uce_pkg::MODE_SELECT_EXTRA_HDINV])) else $error("shift before direction");
    a_ir_zero_only: assert property (@(posedge clk) disable iff (sys_rst)
        ir_pulse_r |-> !ir_bit_r && ir_cnt_r < uce_pkg::IR_PULSE_TICKS)
        else $error("infrared pulse wrong");
    a_ir_idle: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && ir_mode && !loop && !ir_pulse_r |=> !tx_pin) else $error("ir idle high");
    a_sleep_pend: assert property (@(posedge clk) disable iff (sys_rst)
        sleep_r |-> $past(!pending)) else $error("sleep with pending");
    a_sleep_enter: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && entry_ok && !wake |=> sleep_r) else $error("sleep not entered");
    a_wake_up: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && wake |=> !sleep_r) else $error("wake ignored");
    a_msr_clear: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && rd_acc && !key && addr == uce_pkg::A_MSR && mdm_chg == 4'h0
        |=> delta_r == 4'h0) else $error("deltas not cleared");
    a_loop_pins: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && loop |-> !auto_cts_en && !auto_rts_en ##1 rts_n && dtr_n)
        else $error("loopback pins");
    a_div_read: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && rd_acc && !key && lcr_r[uce_pkg::LCR_DIV] && addr == uce_pkg::A_DATA &&
        dll_r != uce_pkg::DIV_ZERO |=> rdata == $past(dll_r)) else $error("divisor read");
    a_flow_rst: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> xon1_r == 8'h00 && xoff2_r == 8'h00) else $error("flow chars reset");
endmodule

//--- bench/uce_remote.sv
`timescale 1ns/1ps
// Far station: the receive line idles at mark and the modem lines stay steady
// until the bench asks for one change on the clear-to-send line.
module uce_remote (
    input wire logic clk,
    output logic rx_pin,
    output logic cts_n,
    output logic dsr_n,
    output logic cd_n,
    output logic ri_n
);
    initial begin
        rx_pin = 1'b1;
        cts_n = 1'b1;
        dsr_n = 1'b1;
        cd_n = 1'b1;
        ri_n = 1'b1;
    end

    task automatic flip_cts();
        @(posedge clk);
        cts_n <= ~cts_n;
    endtask
endmodule

//--- bench/uart_channel_enhanced_features_test.sv
`timescale 1ns/1ps
module uart_channel_enhanced_features_test;
    logic clk, sys_rst, sel_n, wr_n, rd_n, tx_busy, rx_char_valid, tx_shift_bit, peer_ok;
    logic [2:0] addr;
    logic [7:0] wdata, rx_char, rd_val;
    logic [7:0] rdata;
    logic rx_fifo_wr, rx_shift_in, tx_pin, rts_n, dtr_n, auto_rts_en, osc_run, rx_pin;
    logic cts_n, dsr_n, cd_n, ri_n;
    logic clk_en, baud16, tx_bit_start, int_other, tx_go;
    logic [7:0] fifo_fill_level;
    localparam logic [7:0] REV_EXP = 8'h3C;  // Arbitrary value.
    localparam logic [7:0] ID_EXP = 8'hC3;  // Arbitrary value.
    int n_mismatch = 0;
    int cmp_count = 0;

    uce_channel #(.REV_CODE(REV_EXP), .DEV_ID(ID_EXP)) u_uce_channel (.clk(clk),
        .sys_rst(sys_rst), .clk_en(clk_en),
        .channel_select_n(sel_n), .host_write_strobe_n(wr_n), .host_read_strobe_n(rd_n),
        .addr(addr), .wdata(wdata), .rdata(rdata), .thr_wr(), .fcr_wr(), .trg_wr(),
        .rhr_rd(), .wr_byte(), .rhr_in(8'h00), .lsr_in(8'h00), .fc_in(8'h00),
        .fifo_fill_level_in(fifo_fill_level), .isr_src_in(4'h0), .fifo_en(1'b0), .int_other(int_other),
        .baud16(baud16), .tx_shift_bit(tx_shift_bit), .tx_bit_start(tx_bit_start),
        .tx_busy(tx_busy),
        .tx_go(tx_go), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
        .rx_fifo_wr(rx_fifo_wr),
        .rx_shift_in(rx_shift_in), .rx_pin(rx_pin), .tx_pin(tx_pin), .rts_n(rts_n),
        .dtr_n(dtr_n), .cts_n(cts_n), .dsr_n(dsr_n), .cd_n(cd_n), .ri_n(ri_n),
        .auto_rts_en(auto_rts_en), .auto_cts_en(), .sleep_ok(), .peer_sleep_ok(peer_ok),
        .osc_run(osc_run));

    uce_remote u_uce_remote (.clk(clk), .rx_pin(rx_pin), .cts_n(cts_n), .dsr_n(dsr_n),
        .cd_n(cd_n), .ri_n(ri_n));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Strobe and select stay low until the taking edge has passed, then one idle cycle.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        sel_n <= 1'b0;
        wr_n <= 1'b0;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        sel_n <= 1'b1;
        wr_n <= 1'b1;
        @(posedge clk);
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        sel_n <= 1'b0;
        rd_n <= 1'b0;
        addr <= a;
        @(posedge clk);
        sel_n <= 1'b1;
        rd_n <= 1'b1;
        @(posedge clk);
        #1 d = rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rx_one(input logic [7:0] c);
        @(posedge clk);
        rx_char_valid <= 1'b1;
        rx_char <= c;
        #1 check("rx_fifo_wr", {7'h00, rx_fifo_wr}, 8'h01);
        @(posedge clk);
        rx_char_valid <= 1'b0;
    endtask

    task automatic t_decode();
        wr(uce_pkg::A_LCR, uce_pkg::LCR_KEY);
        for (int i = 4; i < 8; i++) begin
            rd(3'(i), rd_val);
            check("flow char reset", rd_val, 8'h00);
        end
        wr(uce_pkg::A_XOFF2, 8'h15);
        rd(uce_pkg::A_XOFF2, rd_val);
        check("pause char second", rd_val, 8'h15);
        wr(uce_pkg::A_LCR, 8'h80);
        rd(uce_pkg::A_DATA, rd_val);
        check("revision", rd_val, REV_EXP);
        rd(uce_pkg::A_IER, rd_val);
        check("device id", rd_val, ID_EXP);
        wr(uce_pkg::A_DATA, 8'h12);
        rd(uce_pkg::A_DATA, rd_val);
        check("divisor low", rd_val, 8'h12);
        wr(uce_pkg::A_LCR, 8'h00);
        wr(uce_pkg::A_SPR, 8'hA5);
        rd(uce_pkg::A_SPR, rd_val);
        check("scratch", rd_val, 8'hA5);
        // With the clock enable low the write must leave no trace.
        clk_en <= 1'b0;
        wr(uce_pkg::A_SPR, 8'h5A);
        clk_en <= 1'b1;
        rd(uce_pkg::A_SPR, rd_val);
        check("frozen write", rd_val, 8'hA5);
    endtask

    task automatic t_special();
        // Word length of five bits: only the low five bits of F5 must match 15.
        rx_one(8'hF5);
        rd(uce_pkg::A_ISR, rd_val);
        check("isr no detect", rd_val, 8'h01);
        wr(uce_pkg::A_LCR, uce_pkg::LCR_KEY);
        wr(uce_pkg::A_EFR, 8'h30);
        wr(uce_pkg::A_LCR, 8'h00);
        rx_one(8'hF5);
        rd(uce_pkg::A_ISR, rd_val);
        check("isr detect", rd_val, 8'h10);
        rd(uce_pkg::A_ISR, rd_val);
        check("isr cleared", rd_val, 8'h01);
    endtask

    task automatic t_sleep();
        wr(uce_pkg::A_IER, 8'h10);
        peer_ok <= 1'b1;
        idle(4);
        check("asleep", {7'h00, osc_run}, 8'h00);
        u_uce_remote.flip_cts();
        idle(4);
        check("woken", {7'h00, osc_run}, 8'h01);
        rd(uce_pkg::A_MSR, rd_val);
        check("modem status", rd_val, 8'h11);
        idle(4);
        check("asleep again", {7'h00, osc_run}, 8'h00);
        int_other <= 1'b1;
        idle(4);
        check("pending wakes", {7'h00, osc_run}, 8'h01);
        int_other <= 1'b0;
        idle(4);
        check("serviced sleeps", {7'h00, osc_run}, 8'h00);
        wr(uce_pkg::A_IER, 8'h00);
        idle(4);
        check("sleep off", {7'h00, osc_run}, 8'h01);
    endtask

    task automatic t_duplex_loop();
        wr(uce_pkg::A_LCR, uce_pkg::LCR_KEY);
        wr(uce_pkg::A_FEATURE_CONTROL_REG, 8'h48);
        wr(uce_pkg::A_EFR, 8'hD0);
        wr(uce_pkg::A_LCR, 8'h00);
        check("auto rts on", {7'h00, auto_rts_en}, 8'h01);
        check("tx_go idle", {7'h00, tx_go}, 8'h00);
        tx_busy <= 1'b1;
        idle(4);
        check("rts sending", {7'h00, rts_n}, 8'h00);
        check("tx_go sending", {7'h00, tx_go}, 8'h01);
        tx_busy <= 1'b0;
        idle(4);
        check("rts released", {7'h00, rts_n}, 8'h01);
        wr(uce_pkg::A_SPR, 8'h08);
        idle(2);
        check("rts inverted", {7'h00, rts_n}, 8'h00);
        rd(uce_pkg::A_SPR, rd_val);
        check("fill level", rd_val, fifo_fill_level);
        wr(uce_pkg::A_MCR, 8'h13);
        tx_shift_bit <= 1'b0;
        idle(3);
        check("auto rts loop", {7'h00, auto_rts_en}, 8'h00);
        check("pins held", {5'h00, rts_n, dtr_n, tx_pin}, 8'h07);
        check("loop data", {7'h00, rx_shift_in}, 8'h00);
        rd(uce_pkg::A_MSR, rd_val);
        check("loop modem bits", {4'h0, rd_val[7:4]}, 8'h03);
    endtask

    // A zero bit must give three ticks of light, a one bit none; ticks come every
    // second clock, so three ticks stand for six clocks on the pin.
    task automatic t_infrared();
        int n;
        logic [7:0] want;
        wr(uce_pkg::A_MCR, 8'h40);
        idle(2);
        check("ir tx idle", {7'h00, tx_pin}, 8'h00);
        check("ir rx pulse", {7'h00, rx_shift_in}, 8'h00);
        wr(uce_pkg::A_LCR, uce_pkg::LCR_KEY);
        wr(uce_pkg::A_FEATURE_CONTROL_REG, 8'h0C);
        wr(uce_pkg::A_LCR, 8'h00);
        for (int b = 0; b < 2; b++) begin
            n = 0;
            @(posedge clk);
            tx_shift_bit <= b[0];
            tx_bit_start <= 1'b1;
            for (int k = 0; k < 24; k++) begin
                @(posedge clk);
                tx_bit_start <= 1'b0;
                baud16 <= k[0];
                #1 n += int'(tx_pin);
            end
            want = (b == 0) ? 8'(2 * int'(uce_pkg::IR_PULSE_TICKS)) : 8'h00;
            check("ir pulse cycles", 8'(n), want);
        end
        baud16 <= 1'b0;
        check("ir rx inverted", {7'h00, rx_shift_in}, 8'h01);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        sys_rst = 1'b1;
        sel_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        addr = 3'h0;
        wdata = 8'h00;
        rx_char = 8'h00;
        rx_char_valid = 1'b0;
        tx_busy = 1'b0;
        tx_shift_bit = 1'b1;
        peer_ok = 1'b0;
        clk_en = 1'b1;
        baud16 = 1'b0;
        tx_bit_start = 1'b0;
        int_other = 1'b0;
        fifo_fill_level = 8'h2C;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_decode();
        t_special();
        t_sleep();
        t_duplex_loop();
        t_infrared();
        end_of_test();
    end
endmodule
